//--- host_model.sv
// Host model: register, coil and frame requests
`timescale 1ns/1ps
module host_model (
    input  wire logic  ref_clk,
    input  wire logic  [15:0] reg_rdata,
    output logic       reg_wr,
    output logic       reg_rd,
    output logic [15:0] reg_addr,
    output logic [15:0] reg_wdata,
    output logic       coil_wr,
    output logic [3:0] coil_wmask,
    output logic [3:0] coil_wdata,
    output logic       msg_done
);
    // ****************************************
    // Requests
    // ****************************************
    initial begin
        {reg_wr, reg_rd, coil_wr, msg_done} = 4'h0;
        {reg_addr, reg_wdata, coil_wmask, coil_wdata} = 40'h0;
    end
    // Idle data lines show the inverse so stale values never match
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(negedge ref_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic coil(input logic [3:0] m, input logic [3:0] d);
        @(negedge ref_clk);
        coil_wr = 1'b1;
        coil_wmask = m;
        coil_wdata = d;
        @(negedge ref_clk);
        coil_wr = 1'b0;
        coil_wdata = ~d;
    endtask
    task automatic frame;
        @(negedge ref_clk);
        msg_done = 1'b1;
        @(negedge ref_clk);
        msg_done = 1'b0;
    endtask
endmodule

//--- io_watchdog_alarm_output_ctrl.sv
// Watchdog, alarm and output control core of a networked I/O module
`timescale 1ns/1ps
module io_watchdog_alarm_output_ctrl
    import io_wdog_pkg::*;
#(
    parameter int N_CH         = 4,
    parameter int SEC_CYCLES   = SEC_CYC,
    parameter int SLOW_CYCLES  = SLOW_FLASH_CYC,
    parameter int FAST_CYCLES  = FAST_FLASH_CYC
) (
    input  wire logic                   ref_clk,
    input  wire logic                   srst,
    input  wire logic                   default_comm_button,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [15:0]            reg_addr,
    input  wire logic [15:0]            reg_wdata,
    output logic      [15:0]            reg_rdata,
    input  wire logic                   reset_slave_req,
    input  wire logic                   chan_access,
    input  wire logic                   coil_wr,
    input  wire logic [N_CH-1:0]        coil_wmask,
    input  wire logic [N_CH-1:0]        coil_wdata,
    output logic      [N_CH-1:0]        coil_state,
    input  wire logic [N_CH*16-1:0]     samples,
    input  wire logic [N_CH*16-1:0]     hi_limits,
    input  wire logic [N_CH*16-1:0]     lo_limits,
    input  wire logic [N_CH*16-1:0]     deadbands,
    input  wire logic [N_CH-1:0]        range_fault,
    input  wire logic                   adc_fault,
    input  wire logic                   flash_cksum_err,
    input  wire logic                   diag_done,
    input  wire logic                   diag_fail,
    input  wire logic                   msg_done,
    output logic                        resp_go,
    output logic      [7:0]             slave_addr,
    output logic      [3:0]             baud_code,
    output logic      [1:0]             parity_mode,
    output logic                        two_stop_bits,
    output logic                        default_mode,
    output logic                        soft_reset,
    output logic                        status_led,
    output logic                        run_led
);

    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        logic [1:0]        btn_sync;
        logic              btn_prev;
        logic              dflt;
        logic [15:0]       wdog_period;
        logic [15:0]       tout_states;
        logic [15:0]       wdog_cnt;
        logic              tout;
        logic [31:0]       sec_cnt;
        logic [31:0]       slow_cnt;
        logic [31:0]       fast_cnt;
        logic              slow_ph;
        logic              fast_ph;
        logic [1:0]        diag_sec;
        logic              diag_run;
        logic [2:0]        diag_sync;
        logic [7:0]        addr;
        logic [3:0]        baud;
        logic [1:0]        parity;
        logic [15:0]       resp_dly;
        logic [15:0]       dly_ticks;
        logic [7:0]        tick_cnt;
        dly_state_t        dly_st;
        logic [N_CH-1:0]   coils;
        logic [N_CH-1:0]   alarm_en;
        logic [N_CH-1:0]   failsafe;
        logic              rst_pend;
        logic [15:0]       rdata;
    } ctrl_state_t;

    ctrl_state_t        s_q;
    ctrl_state_t        s_d;
    logic [N_CH-1:0]    ch_alarm;
    logic               wdog_on;
    logic               sec_tick;
    logic               btn_rise;
    logic [15:0]        status_word;
    logic [N_CH-1:0]    alarm_level;

    // ***************************************************************
    // Limit checkers
    // ***************************************************************
    // Checkers run regardless of any output assignment
    for (genvar i = 0; i < N_CH; i++) begin : g_ch
        limit_chan u_lim (
            .ref_clk  (ref_clk),
            .srst     (srst),
            .sample   (samples[i*16 +: 16]),
            .hi_limit (hi_limits[i*16 +: 16]),
            .lo_limit (lo_limits[i*16 +: 16]),
            .deadband (deadbands[i*16 +: 16]),
            .in_alarm (ch_alarm[i])
        );
    end

    assign wdog_on  = (s_q.wdog_period != WDOG_OFF_LOW) &&
                      (s_q.wdog_period != WDOG_OFF_HIGH);
    assign sec_tick = (s_q.sec_cnt == 32'(SEC_CYCLES - 1));
    assign btn_rise = s_q.btn_sync[1] & ~s_q.btn_prev;

    always_comb begin
        status_word = '0;
        status_word[STAT_WDOG_BIT]  = s_q.tout;
        status_word[STAT_ALARM_BIT] = |ch_alarm;
        status_word[STAT_ADC_BIT]   = adc_fault;
        status_word[STAT_FLASH_BIT] = flash_cksum_err;
        for (int i = 0; i < N_CH; i++) begin
            // Failsafe alarm drives off, like power-down
            alarm_level[i] = ~s_q.failsafe[i];
        end
    end

    // ***************************************************************
    // Next state
    // ***************************************************************
    always_comb begin
        s_d          = s_q;
        s_d.btn_sync = {s_q.btn_sync[0], default_comm_button};
        s_d.btn_prev = s_q.btn_sync[1];
        s_d.rdata    = s_q.rdata;
        if (btn_rise) begin
            s_d.dflt = ~s_q.dflt;
        end

        s_d.sec_cnt = sec_tick ? '0 : s_q.sec_cnt + 32'd1;
        if (s_q.slow_cnt == 32'(SLOW_CYCLES - 1)) begin
            s_d.slow_cnt = '0;
            s_d.slow_ph  = ~s_q.slow_ph;
        end else begin
            s_d.slow_cnt = s_q.slow_cnt + 32'd1;
        end
        if (s_q.fast_cnt == 32'(FAST_CYCLES - 1)) begin
            s_d.fast_cnt = '0;
            s_d.fast_ph  = ~s_q.fast_ph;
        end else begin
            s_d.fast_cnt = s_q.fast_cnt + 32'd1;
        end

        // Diagnostics window of two seconds from reset
        s_d.diag_sync = {s_q.diag_sync[1:0], diag_done};
        if (s_q.diag_run && sec_tick) begin
            if (s_q.diag_sec == 2'(DIAG_SEC - 1)) begin
                s_d.diag_run = 1'b0;
            end
            s_d.diag_sec = s_q.diag_sec + 2'd1;
        end

        // Watchdog counter, restarted by channel traffic
        if (!wdog_on) begin
            s_d.wdog_cnt = s_q.wdog_period;
        end else if (chan_access) begin
            s_d.wdog_cnt = s_q.wdog_period;
        end else if (sec_tick && !s_q.tout) begin
            if (s_q.wdog_cnt <= 16'd1) begin
                s_d.tout     = 1'b1;
                s_d.wdog_cnt = '0;
                if (s_q.tout_states != TOUT_KEEP) begin
                    s_d.coils = s_q.tout_states[N_CH-1:0];
                end
            end else begin
                s_d.wdog_cnt = s_q.wdog_cnt - 16'd1;
            end
        end

        // Alarm control below timeout, frozen while timed out
        if (!s_q.tout && !s_d.tout) begin
            for (int i = 0; i < N_CH; i++) begin
                if (s_q.alarm_en[i] && ch_alarm[i]) begin
                    s_d.coils[i] = alarm_level[i];
                end else if (coil_wr && coil_wmask[i]) begin
                    s_d.coils[i] = coil_wdata[i];
                end
            end
        end else if (s_q.tout) begin
            for (int i = 0; i < N_CH; i++) begin
                // Direct writes still act on channels without alarm control unless the timeout fixed it
                if (coil_wr && coil_wmask[i] && !s_q.alarm_en[i] &&
                    s_q.tout_states == TOUT_KEEP) begin
                    s_d.coils[i] = coil_wdata[i];
                end
            end
        end

        // Register writes
        if (reg_wr) begin
            case (reg_addr)
                REG_CAL_RESET: begin
                    s_d.rst_pend = 1'b1;
                end
                REG_WDOG_PERIOD: begin
                    s_d.wdog_period = reg_wdata;
                    s_d.wdog_cnt    = reg_wdata;
                end
                REG_TIMEOUT_STATES: begin
                    s_d.tout_states = reg_wdata;
                end
                REG_COMM_CFG: begin
                    if (reg_wdata[7:0] >= ADDR_MIN &&
                        reg_wdata[7:0] <= ADDR_MAX) begin
                        s_d.addr = reg_wdata[7:0];
                    end
                    if (reg_wdata[11:8] <= BAUD_MAX_CODE) begin
                        s_d.baud = reg_wdata[11:8];
                    end
                    if (reg_wdata[13:12] != 2'h3) begin
                        s_d.parity = reg_wdata[13:12];
                    end
                end
                REG_RESP_DELAY: begin
                    s_d.resp_dly = (reg_wdata > RESP_DELAY_MAX) ?
                                   RESP_DELAY_MAX : reg_wdata;
                end
                REG_ALARM_CFG: begin
                    s_d.alarm_en = reg_wdata[N_CH-1:0];
                    s_d.failsafe = reg_wdata[N_CH+7:8];
                end
                REG_WDOG_CLEAR: begin
                    // Outputs keep their timeout states
                    if (s_q.tout) begin
                        s_d.tout     = 1'b0;
                        s_d.wdog_cnt = s_q.wdog_period;
                    end
                end
                default: begin
                end
            endcase
        end
        if (reset_slave_req) begin
            s_d.rst_pend = 1'b1;
        end

        if (reg_rd) begin
            case (reg_addr)
                REG_MODULE_STATUS:  s_d.rdata = status_word;
                REG_WDOG_PERIOD:    s_d.rdata = s_q.wdog_period;
                REG_TIMEOUT_STATES: s_d.rdata = s_q.tout_states;
                REG_COMM_CFG: begin
                    s_d.rdata = {2'b00, s_q.parity, s_q.baud, s_q.addr};
                end
                REG_RESP_DELAY:     s_d.rdata = s_q.resp_dly;
                REG_ALARM_CFG: begin
                    s_d.rdata = 16'({s_q.failsafe, 4'h0, s_q.alarm_en});
                end
                default:            s_d.rdata = 16'h0000;
            endcase
        end

        // Response delay sequencer in 1.085 us ticks
        case (s_q.dly_st)
            DLY_IDLE: begin
                if (msg_done) begin
                    s_d.dly_ticks = s_q.resp_dly;
                    s_d.tick_cnt  = '0;
                    s_d.dly_st    = DLY_WAIT;
                end
            end
            DLY_WAIT: begin
                if (s_q.dly_ticks == 16'h0000) begin
                    s_d.dly_st = DLY_SEND;
                end else if (s_q.tick_cnt == 8'(TICK_CYC - 1)) begin
                    s_d.tick_cnt  = '0;
                    s_d.dly_ticks = s_q.dly_ticks - 16'd1;
                end else begin
                    s_d.tick_cnt = s_q.tick_cnt + 8'd1;
                end
            end
            DLY_SEND: begin
                s_d.dly_st = DLY_IDLE;
            end
            default: begin
                s_d.dly_st = DLY_IDLE;
            end
        endcase
    end

    // ***************************************************************
    // Registers
    // ***************************************************************
    // Soft reset is a full reset, so default mode is cleared
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q             <= '0;
            s_q.wdog_period <= WDOG_OFF_LOW;
            s_q.tout_states <= TOUT_RESET;
            s_q.addr        <= ADDR_DEFAULT;
            s_q.baud        <= BAUD_9600;
            s_q.parity      <= PARITY_NONE;
            s_q.dly_st      <= DLY_IDLE;
            s_q.diag_run    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    // Default mode overrides the stored link settings
    assign slave_addr    = s_q.dflt ? ADDR_DEFAULT : s_q.addr;
    assign baud_code     = s_q.dflt ? BAUD_9600 : s_q.baud;
    assign parity_mode   = s_q.dflt ? PARITY_NONE : s_q.parity;
    assign two_stop_bits = (parity_mode == PARITY_NONE);
    assign default_mode  = s_q.dflt;
    assign soft_reset    = s_q.rst_pend;
    assign coil_state    = s_q.coils;
    assign reg_rdata     = s_q.rdata;
    assign resp_go       = (s_q.dly_st == DLY_SEND);

    // Range fault wins over the timeout flash; default mode ignores range faults
    always_comb begin
        if (!s_q.dflt && (|range_fault)) begin
            status_led = 1'b1;
        end else if (s_q.tout) begin
            status_led = s_q.fast_ph;
        end else if (s_q.dflt) begin
            status_led = s_q.slow_ph;
        end else begin
            status_led = 1'b0;
        end
        // Done input is synchronised before use
        if (s_q.diag_run || diag_fail || !s_q.diag_sync[2]) begin
            run_led = s_q.slow_ph;
        end else begin
            run_led = 1'b1;
        end
    end

endmodule

//--- io_wdog_pkg.sv
// Package of constants for the I/O watchdog, alarm and output control block
package io_wdog_pkg;

    // ***************************************************************
    // Register offsets (holding register numbers)
    // ***************************************************************
    localparam logic [15:0] REG_CAL_RESET      = 16'h9c58;
    localparam logic [15:0] REG_MODULE_STATUS  = 16'h0010;
    localparam logic [15:0] REG_WDOG_PERIOD    = 16'h0011;
    localparam logic [15:0] REG_TIMEOUT_STATES = 16'h0012;
    localparam logic [15:0] REG_COMM_CFG       = 16'h0013;
    localparam logic [15:0] REG_RESP_DELAY     = 16'h0014;
    localparam logic [15:0] REG_ALARM_CFG      = 16'h0015;
    localparam logic [15:0] REG_WDOG_CLEAR     = 16'h0016;

    // ***************************************************************
    // Field positions and values
    // ***************************************************************
    localparam int          STAT_WDOG_BIT   = 0;
    localparam int          STAT_ALARM_BIT  = 1;
    localparam int          STAT_ADC_BIT    = 2;
    localparam int          STAT_FLASH_BIT  = 3;
    localparam logic [15:0] WDOG_OFF_LOW    = 16'h0000;
    localparam logic [15:0] WDOG_OFF_HIGH   = 16'hffff;
    localparam logic [15:0] TOUT_KEEP       = 16'hffff;
    localparam logic [15:0] TOUT_RESET      = 16'hffff;
    localparam logic [7:0]  ADDR_DEFAULT    = 8'hf7;
    localparam logic [7:0]  ADDR_MIN        = 8'h01;
    localparam logic [7:0]  ADDR_MAX        = 8'hf7;
    localparam logic [3:0]  BAUD_9600       = 4'h2;
    localparam logic [3:0]  BAUD_MAX_CODE   = 4'h9;
    localparam logic [1:0]  PARITY_NONE     = 2'h0;
    localparam logic [1:0]  PARITY_ODD      = 2'h1;
    localparam logic [1:0]  PARITY_EVEN     = 2'h2;
    localparam logic [15:0] RESP_DELAY_MAX  = 16'hffdc;
    localparam logic [15:0] DEADBAND_SPAN   = 16'h4e20;

    // ***************************************************************
    // Timing
    // ***************************************************************
    localparam int CLK_HZ          = 100_000_000;
    localparam int TICK_PS         = 1085_000;
    localparam int CLK_PS          = 10_000;
    localparam int TICK_CYC        = (TICK_PS + CLK_PS - 1) / CLK_PS;
    localparam int SEC_CYC         = CLK_HZ;
    localparam int DIAG_SEC        = 2;
    localparam int SLOW_FLASH_CYC  = CLK_HZ / 2;
    localparam int FAST_FLASH_CYC  = CLK_HZ / 10;

    typedef enum logic [1:0] {
        DLY_IDLE = 2'b00,
        DLY_WAIT = 2'b01,
        DLY_SEND = 2'b11
    } dly_state_t;

endpackage

//--- io_wdog_sva.sv
// Assertion checker for the watchdog, alarm and output control block
`timescale 1ns/1ps
module io_wdog_sva
    import io_wdog_pkg::*;
#(
    parameter int N_CH = 4
) (
    input wire logic            ref_clk,
    input wire logic            srst,
    input wire logic            default_comm_button,
    input wire logic            reg_wr,
    input wire logic            reg_rd,
    input wire logic [15:0]     reg_addr,
    input wire logic [15:0]     reg_rdata,
    input wire logic            reset_slave_req,
    input wire logic [N_CH-1:0] range_fault,
    input wire logic            resp_go,
    input wire logic [7:0]      slave_addr,
    input wire logic [3:0]      baud_code,
    input wire logic [1:0]      parity_mode,
    input wire logic            two_stop_bits,
    input wire logic            default_mode,
    input wire logic            soft_reset,
    input wire logic            status_led
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    AST_DEF_CFG: assert property (default_mode |-> slave_addr == 8'hf7
        && baud_code == BAUD_9600 && parity_mode == PARITY_NONE)
        else $error("default mode settings wrong");
    AST_BTN: assert property ($rose(default_comm_button) && !default_mode
        |-> ##[1:5] default_mode) else $error("button did not enter default");
    AST_LEAVE: assert property ($fell(srst) |-> !default_mode && !soft_reset)
        else $error("default mode kept over reset");
    // Steady-on fault indication masks the timeout flash outside default mode
    AST_RANGE: assert property ((!default_mode && range_fault != '0) [*3]
        |-> status_led) else $error("range fault not shown");
    AST_ADDR: assert property (slave_addr >= 8'h01 && slave_addr <= 8'hf7)
        else $error("slave address out of range");
    AST_BAUD: assert property (baud_code <= 4'h9)
        else $error("bit rate code out of range");
    AST_STOP: assert property (two_stop_bits == (parity_mode == 2'h0))
        else $error("stop bit count wrong");
    AST_RESP: assert property (resp_go |=> !resp_go)
        else $error("response strobe too long");
    AST_SRST: assert property ((reset_slave_req || (reg_wr
        && reg_addr == REG_CAL_RESET)) |=> soft_reset)
        else $error("reset request ignored");
    AST_RDATA: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without read");
endmodule

bind io_watchdog_alarm_output_ctrl io_wdog_sva #(.N_CH(N_CH)) io_wdog_sva_i (.*);

//--- limit_chan.sv
// One channel of high/low limit checking with deadband hysteresis
`timescale 1ns/1ps
module limit_chan
    import io_wdog_pkg::*;
(
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire logic signed [15:0] sample,
    input  wire logic signed [15:0] hi_limit,
    input  wire logic signed [15:0] lo_limit,
    input  wire logic signed [15:0] deadband,
    output logic                    in_alarm
);

    typedef struct packed {
        logic hi;
        logic lo;
    } lim_state_t;

    lim_state_t   s_q;
    lim_state_t   s_d;
    logic signed [17:0] hi_clear;
    logic signed [17:0] lo_clear;

    always_comb begin
        s_d      = s_q;
        hi_clear = 18'(hi_limit) - 18'(deadband);
        lo_clear = 18'(lo_limit) + 18'(deadband);
        // Deadband in scaled span units, same scale as samples
        if (18'(sample) > 18'(hi_limit)) begin
            s_d.hi = 1'b1;
        end else if (18'(sample) <= hi_clear) begin
            s_d.hi = 1'b0;
        end
        if (18'(sample) < 18'(lo_limit)) begin
            s_d.lo = 1'b1;
        end else if (18'(sample) >= lo_clear) begin
            s_d.lo = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign in_alarm = s_q.hi | s_q.lo;

endmodule

//--- tb_io_watchdog_alarm_output_ctrl.sv
// Testbench for the watchdog, alarm and output control block
`timescale 1ns/1ps
module tb_io_watchdog_alarm_output_ctrl;
    import io_wdog_pkg::*;
    logic ref_clk, srst, default_comm_button, reset_slave_req, chan_access;
    logic reg_wr, reg_rd, coil_wr, msg_done, resp_go, two_stop_bits;
    logic adc_fault, flash_cksum_err, diag_done, diag_fail, default_mode;
    logic soft_reset, status_led, run_led;
    logic [15:0] reg_addr, reg_wdata, reg_rdata;
    logic [3:0]  coil_wmask, coil_wdata, coil_state, range_fault, baud_code;
    logic [63:0] samples, hi_limits, lo_limits, deadbands;
    logic [7:0]  slave_addr;
    logic [1:0]  parity_mode;
    int          errors = 0;
    int          compares = 0;
    int          cyc = 0;

    io_watchdog_alarm_output_ctrl #(.N_CH(4), .SEC_CYCLES(20),
        .SLOW_CYCLES(4), .FAST_CYCLES(2)) io_watchdog_alarm_output_ctrl_i (.*);
    host_model host_model_i (.*);

    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // A run needs about 600 cycles; the ceiling catches hangs
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end
    task automatic chk(input string n, input logic [15:0] s,
                       input logic [15:0] e);
        compares++;
        if (s !== e) begin
            errors++;
            $display("unexpected %s: expected %h seen %h", n, e, s);
        end
    endtask
    task automatic cy(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic do_reset;
        srst = 1'b1;
        cy(3);
        srst = 1'b0;
    endtask
    task automatic st(output logic [15:0] v);
        host_model_i.rd(REG_MODULE_STATUS, v);
    endtask
    task automatic wait_tmo(output logic [15:0] v);
        int i;
        i = 0;
        do begin
            st(v);
            i++;
        end while (v[0] !== 1'b1 && i < 60);
    endtask
    task automatic results;
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        logic [15:0] v;
        host_model_i.rd(REG_WDOG_PERIOD, v);
        chk("wdog period", v, 16'h0000);
        host_model_i.rd(REG_TIMEOUT_STATES, v);
        chk("timeout states", v, 16'hffff);
        host_model_i.rd(16'h00ff, v);
        chk("unmapped", v, 16'h0000);
        adc_fault = 1'b1;
        flash_cksum_err = 1'b1;
        cy(4);
        st(v);
        chk("status faults", v & 16'h000c, 16'h000c);
        adc_fault = 1'b0;
        flash_cksum_err = 1'b0;
        cy(60);
        chk("run led", 16'(run_led), 16'h0001);
        $display("t_reset done");
    endtask
    task automatic t_comm;
        int   n;
        logic s;
        host_model_i.wr(REG_COMM_CFG, 16'h1905);
        host_model_i.wr(REG_COMM_CFG, 16'h1af8);
        cy(1);
        chk("comm", {default_mode, slave_addr, baud_code, parity_mode,
            two_stop_bits}, 16'h02ca);
        default_comm_button = 1'b1;
        n = 0;
        s = status_led;
        repeat (16) begin
            @(negedge ref_clk);
            n += int'(status_led !== s);
            s = status_led;
        end
        chk("slow flash", 16'(n > 1), 16'h0001);
        chk("default", {default_mode, slave_addr, baud_code, parity_mode,
            two_stop_bits}, 16'hfb91);
        default_comm_button = 1'b0;
        cy(4);
        default_comm_button = 1'b1;
        cy(6);
        chk("left", 16'({default_mode, slave_addr}), 16'h0005);
        default_comm_button = 1'b0;
        $display("t_comm done");
    endtask
    task automatic t_wdog;
        logic [15:0] v;
        logic        s;
        host_model_i.wr(REG_TIMEOUT_STATES, 16'h000a);
        host_model_i.coil(4'hf, 4'h5);
        host_model_i.wr(REG_WDOG_PERIOD, 16'h0002);
        repeat (8) begin
            chan_access = 1'b1;
            cy(1);
            chan_access = 1'b0;
            cy(9);
        end
        st(v);
        chk("kept alive", 16'(v[0]), 16'h0000);
        chk("coils", 16'(coil_state), 16'h0005);
        wait_tmo(v);
        chk("timeout flag", 16'(v[0]), 16'h0001);
        chk("timeout coils", 16'(coil_state), 16'h000a);
        s = status_led;
        cy(2);
        chk("fast flash", 16'(status_led ^ s), 16'h0001);
        host_model_i.wr(REG_WDOG_PERIOD, 16'h0000);
        host_model_i.wr(REG_WDOG_CLEAR, 16'h0000);
        st(v);
        chk("cleared", 16'({v[0], coil_state}), 16'h000a);
        host_model_i.wr(REG_TIMEOUT_STATES, 16'hffff);
        host_model_i.coil(4'hf, 4'h3);
        host_model_i.wr(REG_WDOG_PERIOD, 16'h0002);
        wait_tmo(v);
        chk("kept coils", 16'({v[0], coil_state}), 16'h0013);
        host_model_i.wr(REG_WDOG_PERIOD, 16'h0000);
        host_model_i.wr(REG_WDOG_CLEAR, 16'h0000);
        $display("t_wdog done");
    endtask
    task automatic t_alarm;
        logic [15:0] v;
        range_fault = 4'h4;
        cy(12);
        range_fault = 4'h0;
        host_model_i.wr(REG_ALARM_CFG, 16'h0203);
        samples = {32'h0000_0000, 16'hff6a, 16'h0096};
        cy(3);
        host_model_i.coil(4'hf, 4'hf);
        st(v);
        chk("alarm coils", 16'(coil_state), 16'h000d);
        chk("alarm flag", 16'(v[1]), 16'h0001);
        samples = {32'h0000_0000, 16'hffa1, 16'h005f};
        cy(3);
        st(v);
        chk("deadband hold", 16'(v[1]), 16'h0001);
        samples = {32'h0000_0000, 16'hffa7, 16'h0059};
        cy(3);
        st(v);
        chk("alarm clear", 16'(v[1]), 16'h0000);
        samples = {16'h0000, 16'h0096, 32'h0000_0000};
        cy(3);
        st(v);
        chk("unassigned", 16'(v[1]), 16'h0001);
        samples = '0;
        $display("t_alarm done");
    endtask
    task automatic t_resp;
        int n;
        host_model_i.wr(REG_RESP_DELAY, 16'h0002);
        host_model_i.frame();
        n = 0;
        while (resp_go !== 1'b1 && n < 400) begin
            @(negedge ref_clk);
            n++;
        end
        chk("resp delay", 16'(n >= 216 && n <= 232), 16'h0001);
        $display("t_resp done");
    endtask
    task automatic t_sreset;
        reset_slave_req = 1'b1;
        cy(1);
        reset_slave_req = 1'b0;
        cy(1);
        chk("slave reset", 16'(soft_reset), 16'h0001);
        do_reset();
        default_comm_button = 1'b1;
        cy(6);
        default_comm_button = 1'b0;
        host_model_i.wr(REG_CAL_RESET, 16'h0000);
        cy(1);
        chk("reg reset", 16'({default_mode, soft_reset}), 16'h0003);
        do_reset();
        chk("after reset", 16'({default_mode, soft_reset}), 16'h0000);
        $display("t_sreset done");
    endtask

    initial begin
        {default_comm_button, reset_slave_req, chan_access} = 3'h0;
        {adc_fault, flash_cksum_err, diag_fail} = 3'h0;
        diag_done = 1'b1;
        range_fault = 4'h0;
        samples = '0;
        hi_limits = {4{16'h0064}};
        lo_limits = {4{16'hff9c}};
        deadbands = {4{16'h000a}};
        do_reset();
        t_reset();
        t_comm();
        t_wdog();
        t_alarm();
        t_resp();
        t_sreset();
        results();
    end
endmodule
